// ### bench/smcws_chk.sv
`timescale 1ns/1ps
module smcws_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire smcws_pkg::smcws_bus_s bus,
    input wire logic [31:0] rdata_ff,
    input wire logic reqTaken_ff,
    input wire logic [1:0] gapKind_ff,
    input wire logic [3:0] csN_ff,
    input wire logic readStrobeN_ff,
    input wire logic writeStrobeN_ff
);
    import smcws_pkg::*;
    logic wrSeen_ff, modePend_ff, modeWr, regRd;
    logic [3:0] lastCs_ff;
    assign modeWr = bus.wr && bus.addr < 8'h40 && bus.addr[3:0] == 4'hC;
    assign regRd = bus.rd && bus.addr < 8'h40 && bus.addr[1:0] == 2'h0;
    function automatic logic [31:0] rv(input logic [1:0] k);
        return k == 2'h0 ? SETUP_RST : k == 2'h1 ? PULSE_RST :
            k == 2'h2 ? CYCLE_RST : MODE_RST;
    endfunction
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrSeen_ff <= 1'h0;
        end else if (bus.wr) begin
            wrSeen_ff <= 1'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            modePend_ff <= 1'h0;
        end else if (modeWr) begin
            modePend_ff <= 1'h1;
        end else if (gapKind_ff == 2'h1 || gapKind_ff == 2'h3) begin
            modePend_ff <= 1'h0;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            lastCs_ff <= 4'hF;
        end else if (reqTaken_ff) begin
            lastCs_ff <= csN_ff;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    chk_reset_vals: assert property (
        regRd && !wrSeen_ff |=> rdata_ff == rv($past(bus.addr[3:2])))
        else $error("timing register lost its reset value");
    chk_key_hidden: assert property (
        bus.rd && (bus.addr == KEY1_OFF || bus.addr == KEY2_OFF)
        |=> rdata_ff == 32'h0) else $error("key register read back");
    chk_cs_switch: assert property (
        reqTaken_ff && $past(reqTaken_ff) |-> csN_ff == $past(csN_ff))
        else $error("select changed with no idle cycle");
    chk_idle_high: assert property (
        gapKind_ff == 2'h1 |-> csN_ff == 4'hF && readStrobeN_ff &&
        writeStrobeN_ff) else $error("control line active in idle cycle");
    chk_gap_empty: assert property (
        gapKind_ff != 2'h0 |-> !reqTaken_ff)
        else $error("access taken in a wait cycle");
    chk_early_same: assert property (
        reqTaken_ff && !readStrobeN_ff && $past(gapKind_ff) == 2'h2
        |-> csN_ff == lastCs_ff) else $error("early wait across selects");
    chk_reload_gap: assert property (
        reqTaken_ff && $past(modePend_ff) |-> $past(gapKind_ff) inside
        {2'h1, 2'h3}) else $error("no reload cycle after mode write");
    chk_rd_wr_gap: assert property (
        reqTaken_ff && $past(reqTaken_ff) && !$past(readStrobeN_ff)
        |-> !readStrobeN_ff) else $error("write straight after read");
    cov_cs_gap: cover property (gapKind_ff == 2'h1);
    cov_early_gap: cover property (gapKind_ff == 2'h2);
    cov_reload_gap: cover property (gapKind_ff == 2'h3);
endmodule
bind smcws_sequencer smcws_chk u_chk (
    .clock(clock), .rst_b(rst_b), .bus(bus), .rdata_ff(rdata_ff),
    .reqTaken_ff(reqTaken_ff), .gapKind_ff(gapKind_ff), .csN_ff(csN_ff),
    .readStrobeN_ff(readStrobeN_ff), .writeStrobeN_ff(writeStrobeN_ff)
);

// ### bench/smcws_mem_model.sv
`timescale 1ns/1ps
module smcws_mem_model (
    input wire logic clock,
    input wire logic [3:0] csN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic [31:0] wdata,
    input wire logic slow,
    output logic [31:0] rdata,
    output logic wrFeedback
);
    logic [31:0] mem [4];
    logic [31:0] last;
    logic fbDly;
    int idx;
    initial begin
        last = 32'h0;
        fbDly = 1'h1;
    end
    assign idx = !csN[1] ? 1 : !csN[2] ? 2 : !csN[3] ? 3 : 0;
    // An idle bus shows a pattern that changes every cycle.
    assign rdata = (!readStrobeN && csN != 4'hF) ? mem[idx] : ~last;
    always @(posedge clock) begin
        last <= rdata;
        fbDly <= writeStrobeN;
        if (!writeStrobeN && csN != 4'hF) begin
            mem[idx] <= wdata;
        end
    end
    // A heavily loaded pad returns the rising strobe a cycle late.
    assign wrFeedback = slow ? fbDly : writeStrobeN;
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import smcws_pkg::*;
    logic clock, rst_b, slowClock, slowFb, wrStrobeFeedback, rdPrev, mrdPrev;
    logic reqTaken_ff, readStrobeN_ff, writeStrobeN_ff;
    logic [1:0] gapKind_ff, gapSeen;
    logic [2:0] g;
    logic [3:0] csN_ff;
    logic [9:0] wrHold_ff;
    logic [31:0] memRdata, rdata_ff, memWdata_ff, plainRdata_ff, r;
    logic [31:0] shadow [4];
    logic [31:0] rq [$];
    logic [31:0] mq [$];
    logic [2:0] gq [$];
    int fails, n_tests, seed;
    smcws_bus_s bus;
    smcws_req_s req;
    smcws_sequencer uut (
        .clock(clock), .rst_b(rst_b), .bus(bus), .rdata_ff(rdata_ff),
        .req(req), .slowClock(slowClock), .memRdata(memRdata),
        .wrStrobeFeedback(wrStrobeFeedback), .reqTaken_ff(reqTaken_ff),
        .gapKind_ff(gapKind_ff), .memWdata_ff(memWdata_ff),
        .plainRdata_ff(plainRdata_ff), .csN_ff(csN_ff),
        .readStrobeN_ff(readStrobeN_ff), .writeStrobeN_ff(writeStrobeN_ff),
        .wrHold_ff(wrHold_ff), .rdHold_ff()
    );
    smcws_mem_model mdl (
        .clock(clock), .csN(csN_ff), .readStrobeN(readStrobeN_ff),
        .writeStrobeN(writeStrobeN_ff), .wdata(memWdata_ff), .slow(slowFb),
        .rdata(memRdata), .wrFeedback(wrStrobeFeedback)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    function automatic logic [31:0] rv(input logic [1:0] k);
        return k == 2'h0 ? SETUP_RST : k == 2'h1 ? PULSE_RST :
            k == 2'h2 ? CYCLE_RST : MODE_RST;
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        bus <= '{a, v, 1'h1, 1'h0};
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        bus <= '{a, 32'h0, 1'h0, 1'h1};
        rq.push_back(e);
    endtask
    task automatic idle();
        @(posedge clock);
        bus <= '0;
    endtask
    // Holds the request until the block reports it taken, for at most 20 cycles.
    task automatic acc(input logic w, input logic [1:0] c,
        input logic [31:0] v, input logic [2:0] eg);
        int n;
        gq.push_back(eg);
        if (!w) mq.push_back(shadow[c]);
        if (w) shadow[c] = v;
        req <= '{1'h1, w, c, v};
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (reqTaken_ff !== 1'h1 && n < 20);
    endtask
    always @(posedge clock) begin
        #1;
        if (rdPrev) check(rdata_ff, rq.pop_front());
        rdPrev = bus.rd;
        if (mrdPrev) check(plainRdata_ff, mq.pop_front());
        mrdPrev = reqTaken_ff && !readStrobeN_ff;
        if (gapKind_ff != 2'h0) gapSeen = gapKind_ff;
        if (reqTaken_ff) begin
            g = gq.pop_front();
            if (g != 3'h7) check(32'(gapSeen), 32'(g));
            gapSeen = 2'h0;
        end
    end
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #20000;
        fails++;
        finish_test();
    end
    initial begin
        seed = 32'hF192;
        fails = 0;
        n_tests = 0;
        rst_b = 1'h0;
        bus = '0;
        req = '0;
        slowClock = 1'h0;
        slowFb = 1'h0;
        rdPrev = 1'h0;
        mrdPrev = 1'h0;
        gapSeen = 2'h0;
        repeat (10) @(posedge clock);
        rst_b <= 1'h1;
        for (int a = 0; a < 64; a += 4) rd(8'(a), rv(2'(a / 4)));
        wr(KEY1_OFF, $random(seed));
        wr(KEY2_OFF, $random(seed));
        rd(KEY1_OFF, 32'h0);
        rd(KEY2_OFF, 32'h0);
        rd(8'hF0, 32'h0);
        idle();
        $display("register test done");
        acc(1'h1, 2'h0, 32'hA5A50001, 3'h7);
        acc(1'h1, 2'h0, 32'h5A5A0002, 3'h0);
        acc(1'h0, 2'h0, 32'h0, 3'h0);
        acc(1'h0, 2'h2, 32'h0, 3'h1);
        acc(1'h1, 2'h2, 32'h00C30003, 3'h2);
        acc(1'h0, 2'h2, 32'h0, 3'h0);
        req.valid <= 1'h0;
        repeat (2) @(posedge clock);
        check(32'(wrHold_ff), 32'h1);
        wr(SCRMODE_OFF, 32'h2);
        idle();
        acc(1'h1, 2'h1, 32'h3C3C1111, 3'h7);
        acc(1'h1, 2'h0, 32'h3C3C2222, 3'h1);
        acc(1'h0, 2'h1, 32'h0, 3'h7);
        acc(1'h0, 2'h1, 32'h0, 3'h0);
        acc(1'h1, 2'h1, 32'h0F0F3333, 3'h7);
        req.valid <= 1'h0;
        check(32'(mdl.mem[1] !== 32'h3C3C1111), 32'h1);
        check(mdl.mem[0], 32'h3C3C2222);
        $display("access and scramble test done");
        wr(8'h30, 32'h0);
        wr(8'h38, 32'h00010001);
        wr(8'h3C, MODE_RST);
        idle();
        acc(1'h1, 2'h3, 32'h12345678, 3'h1);
        acc(1'h1, 2'h3, 32'h9ABCDEF0, 3'h0);
        acc(1'h0, 2'h3, 32'h0, 3'h2);
        req.valid <= 1'h0;
        check(32'(wrHold_ff), 32'h0);
        wr(MODE_OFF, MODE_RST);
        idle();
        acc(1'h0, 2'h3, 32'h0, 3'h3);
        req.valid <= 1'h0;
        for (int s = 1; s >= 0; s--) begin
            @(posedge clock);
            slowClock <= 1'(s);
            repeat (4) @(posedge clock);
            acc(1'h0, 2'h3, 32'h0, 3'h3);
            req.valid <= 1'h0;
        end
        $display("wait state test done");
        slowFb <= 1'h1;
        repeat (24) begin
            r = $random(seed);
            acc(r[0], r[2:1], $random(seed), 3'h7);
        end
        for (int c = 0; c < 4; c++) acc(1'h0, 2'(c), 32'h0, 3'h7);
        req.valid <= 1'h0;
        repeat (4) @(posedge clock);
        $display("random test done");
        finish_test();
    end
endmodule

// ### src/smcws_pkg.sv
package smcws_pkg;

    localparam int CHIP_SELECT_N = 4;

    // Register word offsets (byte addresses).
    localparam logic [7:0] SETUP_OFF = 8'h00;
    localparam logic [7:0] PULSE_OFF = 8'h04;
    localparam logic [7:0] CYCLE_OFF = 8'h08;
    localparam logic [7:0] MODE_OFF = 8'h0C;
    localparam logic [7:0] CS_STRIDE = 8'h10;
    localparam logic [7:0] SCRMODE_OFF = 8'h80;
    localparam logic [7:0] KEY1_OFF = 8'h84;
    localparam logic [7:0] KEY2_OFF = 8'h88;
    localparam logic [7:0] STATUS_OFF = 8'h8C;

    // Reset values.
    localparam logic [31:0] SETUP_RST = 32'h01010101;
    localparam logic [31:0] PULSE_RST = 32'h01010101;
    localparam logic [31:0] CYCLE_RST = 32'h00030003;
    localparam logic [31:0] MODE_RST = 32'h00000003;

    // Field positions.
    localparam int RD_MODE_BIT = 0;
    localparam int WR_MODE_BIT = 1;
    localparam int SU_WE_LSB = 0;
    localparam int SU_CSWR_LSB = 8;
    localparam int SU_RD_LSB = 16;
    localparam int SU_CSRD_LSB = 24;
    localparam int SU_W = 6;
    localparam int PU_W = 7;
    localparam int CY_W = 9;
    localparam int CY_WR_LSB = 0;
    localparam int CY_RD_LSB = 16;

    typedef enum logic [1:0] {
        SMCWS_GAP_NONE,
        SMCWS_GAP_CS,
        SMCWS_GAP_EARLY,
        SMCWS_GAP_RELOAD
    } smcws_gap_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] cs;
        logic [31:0] data;
    } smcws_req_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } smcws_bus_s;

endpackage

// ### src/smcws_sequencer.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module smcws_sequencer
    import smcws_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire smcws_pkg::smcws_bus_s bus,
    output logic [31:0] rdata_ff,
    input wire smcws_pkg::smcws_req_s req,
    input wire logic slowClock,
    input wire logic wrStrobeFeedback,
    input wire logic [31:0] memRdata,
    output logic reqTaken_ff,
    output logic [1:0] gapKind_ff,
    output logic [31:0] memWdata_ff,
    output logic [31:0] plainRdata_ff,
    output logic [CHIP_SELECT_N-1:0] csN_ff,
    output logic readStrobeN_ff,
    output logic writeStrobeN_ff,
    output logic [9:0] wrHold_ff,
    output logic [9:0] rdHold_ff
);
    import smcws_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    logic [31:0] setup_ff [CHIP_SELECT_N];
    logic [31:0] pulse_ff [CHIP_SELECT_N];
    logic [31:0] cycle_ff [CHIP_SELECT_N];
    logic [31:0] mode_ff [CHIP_SELECT_N];
    logic [CHIP_SELECT_N-1:0] scrEn_ff;
    logic [31:0] key1_ff;
    logic [31:0] key2_ff;
    logic reloadPend_ff;
    logic slowSync1_ff;
    logic slowSync2_ff;
    logic slowPrev_ff;
    logic fbSync1_ff;
    logic fbSync2_ff;

    function automatic logic csHit(input logic [7:0] a, input int cs,
                                   input logic [7:0] off);
        return a == 8'((cs * CS_STRIDE) + off);
    endfunction

    genvar g;
    generate
        for (g = 0; g < CHIP_SELECT_N; g++) begin : gCs
            always_ff @(posedge clock) begin
                if (!rst_b) begin
                    setup_ff[g] <= SETUP_RST;
                    pulse_ff[g] <= PULSE_RST;
                    cycle_ff[g] <= CYCLE_RST;
                    mode_ff[g] <= MODE_RST;
                end else if (bus.wr) begin
                    if (csHit(bus.addr, g, SETUP_OFF)) begin
                        setup_ff[g] <= bus.wdata;
                    end
                    if (csHit(bus.addr, g, PULSE_OFF)) begin
                        pulse_ff[g] <= bus.wdata;
                    end
                    if (csHit(bus.addr, g, CYCLE_OFF)) begin
                        cycle_ff[g] <= bus.wdata;
                    end
                    if (csHit(bus.addr, g, MODE_OFF)) begin
                        mode_ff[g] <= bus.wdata;
                    end
                end
            end
        end
    endgenerate

    logic modeWrite;
    always_comb begin
        modeWrite = 1'b0;
        for (int i = 0; i < CHIP_SELECT_N; i++) begin
            if (bus.wr && csHit(bus.addr, i, MODE_OFF)) begin
                modeWrite = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            scrEn_ff <= '0;
            key1_ff <= '0;
            key2_ff <= '0;
        end else if (bus.wr) begin
            if (bus.addr == SCRMODE_OFF) begin
                scrEn_ff <= bus.wdata[CHIP_SELECT_N-1:0];
            end
            if (bus.addr == KEY1_OFF) begin
                key1_ff <= bus.wdata;
            end
            if (bus.addr == KEY2_OFF) begin
                key2_ff <= bus.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port; keys read as zero.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdata_ff <= '0;
        end else if (bus.rd) begin
            rdata_ff <= '0;
            for (int i = 0; i < CHIP_SELECT_N; i++) begin
                if (csHit(bus.addr, i, SETUP_OFF)) rdata_ff <= setup_ff[i];
                if (csHit(bus.addr, i, PULSE_OFF)) rdata_ff <= pulse_ff[i];
                if (csHit(bus.addr, i, CYCLE_OFF)) rdata_ff <= cycle_ff[i];
                if (csHit(bus.addr, i, MODE_OFF)) rdata_ff <= mode_ff[i];
            end
            if (bus.addr == SCRMODE_OFF) begin
                rdata_ff <= {{(32-CHIP_SELECT_N){1'b0}}, scrEn_ff};
            end
            if (bus.addr == STATUS_OFF) begin
                rdata_ff <= {29'h0, reloadPend_ff, gapKind_ff};
            end
        end else begin
            rdata_ff <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            slowSync1_ff <= 1'b0;
            slowSync2_ff <= 1'b0;
            slowPrev_ff <= 1'b0;
            fbSync1_ff <= 1'b1;
            fbSync2_ff <= 1'b1;
        end else begin
            slowSync1_ff <= slowClock;
            slowSync2_ff <= slowSync1_ff;
            slowPrev_ff <= slowSync2_ff;
            fbSync1_ff <= wrStrobeFeedback;
            fbSync2_ff <= fbSync1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gap decision between the last and the next access.
    logic lastValid_ff;
    logic lastWrite_ff;
    logic [1:0] lastCs_ff;
    logic gapDone_ff;
    logic [9:0] effSetup [4];
    logic [9:0] effPulse [4];
    logic [9:0] effCycle [2];
    smcws_gap_e gap;

    function automatic logic [9:0] setupVal(input logic [SU_W-1:0] s);
        return {4'h0, s[5], 5'h00} * 10'h004 + {5'h00, s[4:0]};
    endfunction
    function automatic logic [9:0] pulseVal(input logic [PU_W-1:0] p);
        return {p[6], 8'h00} + {4'h0, p[5:0]} + {p[6], 9'h000} * 10'h000;
    endfunction
    function automatic logic [9:0] cycleVal(input logic [CY_W-1:0] c);
        return {c[8:7], 8'h00} + {3'h0, c[6:0]};
    endfunction

    logic [31:0] curSetup;
    logic [31:0] curPulse;
    logic [31:0] curCycle;
    logic [31:0] curMode;
    logic [31:0] lastSetup_ff;
    logic [31:0] lastPulse_ff;
    logic [31:0] lastCycle_ff;
    logic [31:0] lastMode_ff;
    logic [9:0] lastWeHold;
    logic [9:0] lastCsWrHold;
    logic [9:0] nxtRdHold;

    always_comb begin
        curSetup = setup_ff[req.cs];
        curPulse = pulse_ff[req.cs];
        curCycle = cycle_ff[req.cs];
        curMode = mode_ff[req.cs];
        for (int i = 0; i < 4; i++) begin
            effSetup[i] = setupVal(lastSetup_ff[i*8 +: SU_W]);
            effPulse[i] = pulseVal(lastPulse_ff[i*8 +: PU_W]);
        end
        effCycle[0] = cycleVal(lastCycle_ff[CY_WR_LSB +: CY_W]);
        effCycle[1] = cycleVal(lastCycle_ff[CY_RD_LSB +: CY_W]);
        lastWeHold = effCycle[0] - effSetup[0] - effPulse[0];
        lastCsWrHold = effCycle[0] - effSetup[1] - effPulse[1];
        nxtRdHold = cycleVal(curCycle[CY_RD_LSB +: CY_W])
            - setupVal(curSetup[SU_RD_LSB +: SU_W])
            - pulseVal(curPulse[SU_RD_LSB +: PU_W]);
    end

    logic earlyNeed;
    always_comb begin
        earlyNeed = 1'b0;
        if (lastWrite_ff && !req.write) begin
            if (lastMode_ff[WR_MODE_BIT]) begin
                if (lastWeHold == 10'h000 && (curMode[RD_MODE_BIT]
                    ? curSetup[SU_RD_LSB +: SU_W] == '0
                    : curSetup[SU_CSRD_LSB +: SU_W] == '0)) begin
                    earlyNeed = 1'b1;
                end
                if (lastWeHold == 10'h000 && !fbSync2_ff) begin
                    earlyNeed = 1'b1;
                end
            end else if (lastCsWrHold == 10'h000 &&
                         curSetup[SU_CSRD_LSB +: SU_W] == '0) begin
                earlyNeed = 1'b1;
            end
        end
    end

    always_comb begin
        gap = SMCWS_GAP_NONE;
        if (lastValid_ff && !gapDone_ff) begin
            if (req.cs != lastCs_ff) begin
                gap = SMCWS_GAP_CS;
            end else if (reloadPend_ff) begin
                gap = SMCWS_GAP_RELOAD;
            end else if (earlyNeed) begin
                gap = SMCWS_GAP_EARLY;
            end else if (!lastWrite_ff && req.write) begin
                gap = SMCWS_GAP_EARLY;
            end
        end else if (!lastValid_ff && reloadPend_ff && !gapDone_ff) begin
            gap = SMCWS_GAP_RELOAD;
        end
    end

    logic take;
    assign take = req.valid && gap == SMCWS_GAP_NONE;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reloadPend_ff <= 1'b0;
        end else if (modeWrite || slowSync2_ff != slowPrev_ff) begin
            reloadPend_ff <= 1'b1;
        end else if (req.valid && gap != SMCWS_GAP_NONE) begin
            reloadPend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            gapDone_ff <= 1'b0;
            gapKind_ff <= SMCWS_GAP_NONE;
            reqTaken_ff <= 1'b0;
        end else begin
            gapDone_ff <= req.valid && gap != SMCWS_GAP_NONE;
            gapKind_ff <= req.valid ? gap : SMCWS_GAP_NONE;
            reqTaken_ff <= take;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            lastValid_ff <= 1'b0;
            lastWrite_ff <= 1'b0;
            lastCs_ff <= '0;
            lastSetup_ff <= SETUP_RST;
            lastPulse_ff <= PULSE_RST;
            lastCycle_ff <= CYCLE_RST;
            lastMode_ff <= MODE_RST;
        end else if (take) begin
            lastValid_ff <= 1'b1;
            lastWrite_ff <= req.write;
            lastCs_ff <= req.cs;
            lastSetup_ff <= curSetup;
            lastPulse_ff <= curPulse;
            lastCycle_ff <= curCycle;
            lastMode_ff <= curMode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobes, scrambling and hold outputs.
    logic [31:0] keyStream;
    assign keyStream = key1_ff ^ {key2_ff[15:0], key2_ff[31:16]};

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            csN_ff <= '1;
            readStrobeN_ff <= 1'b1;
            writeStrobeN_ff <= 1'b1;
            memWdata_ff <= '0;
            plainRdata_ff <= '0;
            wrHold_ff <= '0;
            rdHold_ff <= '0;
        end else begin
            csN_ff <= '1;
            readStrobeN_ff <= 1'b1;
            writeStrobeN_ff <= 1'b1;
            if (take) begin
                csN_ff[req.cs] <= 1'b0;
                readStrobeN_ff <= req.write;
                writeStrobeN_ff <= !req.write;
                memWdata_ff <= scrEn_ff[req.cs]
                    ? req.data ^ keyStream : req.data;
            end else if (gap == SMCWS_GAP_EARLY && lastWrite_ff &&
                         lastMode_ff[WR_MODE_BIT]) begin
                csN_ff[lastCs_ff] <= 1'b0;
            end
            plainRdata_ff <= scrEn_ff[lastCs_ff]
                ? memRdata ^ keyStream : memRdata;
            wrHold_ff <= lastWeHold;
            rdHold_ff <= nxtRdHold;
        end
    end

endmodule
